// file: rtl/sos_pkg.sv
package sos_pkg;
	// protective functions, indication outputs, field pairs per function
	localparam int NFN = 2;
	localparam int NSIG = 9;
	localparam int SELW = 4;
	localparam int NSRC = 16;
	localparam int FLDW = 4;
	localparam logic [FLDW-1:0] FLD_CNT = 4'hA;

	// register byte addresses
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STAT = 8'h04;
	localparam logic [7:0] ADR_FIELD = 8'h08;
	localparam logic [7:0] ADR_DLY = 8'h0C;
	localparam logic [7:0] ADR_SEL0 = 8'h10;
	localparam logic [7:0] ADR_SEL1 = 8'h14;
	localparam logic [7:0] ADR_IRQ_ST = 8'h18;
	localparam logic [7:0] ADR_IRQ_CLR = 8'h1C;
	localparam logic [7:0] ADR_IRQ_EN = 8'h20;

	// control register fields; auto restart and contactor monitor hold one bit per function
	localparam int CTL_DUAL = 0;
	localparam int CTL_AUTO = 1;
	localparam int CTL_CFB = 3;
	localparam int CTL_DLY_EN = 5;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [31:0] DLY_RST = 32'h0000_0000;

	// status register fields, one bit per function from each base
	localparam int STB_ON = 0;
	localparam int STB_READY = 2;
	localparam int STB_ERR = 4;
	localparam int STB_FERR = 6;
	localparam int STB_OCC = 8;
	localparam int STB_WARN = 10;

	// interrupt status bits, one bit per function from each base
	localparam int NIRQ = 8;
	localparam int IRQ_OFF = 0;
	localparam int IRQ_ERR = 2;
	localparam int IRQ_WARN = 4;
	localparam int IRQ_FLD = 6;

	// timing
	localparam int CLK_KHZ = 125_000;
	localparam int BLINK_HALF_MS = 250;
	localparam int CFB_MS = 300;
	localparam int BLINK_CYC = BLINK_HALF_MS * CLK_KHZ;
	localparam int CFB_CYC = CFB_MS * CLK_KHZ;

	// indication output sources
	localparam logic [SELW-1:0] SRC_ZERO = 4'h0;
	localparam logic [SELW-1:0] SRC_ON_A = 4'h1;
	localparam logic [SELW-1:0] SRC_ON_B = 4'h2;
	localparam logic [SELW-1:0] SRC_WARN_A = 4'h3;
	localparam logic [SELW-1:0] SRC_WARN_B = 4'h4;
	localparam logic [SELW-1:0] SRC_ERR_A = 4'h5;
	localparam logic [SELW-1:0] SRC_ERR_B = 4'h6;
	localparam logic [SELW-1:0] SRC_READY_A = 4'h7;
	localparam logic [SELW-1:0] SRC_READY_B = 4'h8;
	localparam logic [SELW-1:0] SRC_FERR_A = 4'h9;
	localparam logic [SELW-1:0] SRC_FERR_B = 4'hA;
	localparam logic [SELW-1:0] SRC_OCC_A = 4'hB;
	localparam logic [SELW-1:0] SRC_OCC_B = 4'hC;

	typedef enum logic [1:0] {
		CH_LOCK = 2'b00,
		CH_ON = 2'b01,
		CH_ERR = 2'b10
	} sos_ch_st_t;

	function automatic logic sos_fld_ok(input logic [FLDW-1:0] sel);
		sos_fld_ok = (sel < FLD_CNT);
	endfunction
endpackage

// file: rtl/sos_chan_if.sv
`timescale 1ns/1ps
interface sos_chan_if;
	import sos_pkg::*;
	logic occ;
	logic ack;
	logic auto_rst;
	logic cfb_en;
	logic fb;
	logic [1:0] rb;
	logic fault;
	logic [1:0] pair;
	logic on;
	logic ready;
	logic err;
	modport chan (input occ, ack, auto_rst, cfb_en, fb, rb, fault,
		output pair, on, ready, err);
	modport ctrl (output occ, ack, auto_rst, cfb_en, fb, rb, fault,
		input pair, on, ready, err);
endinterface

// file: rtl/sos_chan.sv
`timescale 1ns/1ps
module sos_chan import sos_pkg::*; #(
	parameter int CFB_LIM = CFB_CYC
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// function signals
	sos_chan_if.chan cif
);
	typedef struct packed {
		sos_ch_st_t st;
		logic [31:0] cfb_cnt;
	} sos_chan_st_t;

	sos_chan_st_t r;
	sos_chan_st_t n;
	logic fault_now;

	always_comb begin
		n = r;
		fault_now = 1'b0;
		// contactors must follow the pair: released while off, pulled in while on
		if (cif.cfb_en && (cif.fb != (r.st != CH_ON))) begin // [R11]
			n.cfb_cnt = r.cfb_cnt + 32'h0000_0001;
		end else begin
			n.cfb_cnt = 32'h0000_0000;
		end
		if (r.cfb_cnt == 32'(CFB_LIM - 1)) begin // [R11]
			fault_now = 1'b1;
		end
		if (cif.rb[0] != cif.rb[1]) begin // [R13]
			fault_now = 1'b1;
		end
		if (cif.fault) begin
			fault_now = 1'b1;
		end
		unique case (r.st)
			CH_LOCK: begin
				if (fault_now) begin
					n.st = CH_ERR;
				end else if (!cif.occ && (cif.auto_rst || cif.ack)) begin // [R2]
					n.st = CH_ON;
				end
			end
			CH_ON: begin
				if (fault_now) begin
					n.st = CH_ERR;
				end else if (cif.occ) begin // [R1]
					n.st = CH_LOCK;
				end
			end
			CH_ERR: begin
				if (!fault_now && cif.ack && !cif.occ) begin
					n.st = CH_LOCK;
				end
			end
			default: begin
				n.st = CH_ERR;
			end
		endcase
		if (n.st == CH_ERR) begin
			n.cfb_cnt = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '{st: CH_LOCK, cfb_cnt: 32'h0000_0000};
		end else begin
			r <= n;
		end
	end

	assign cif.pair = {2{r.st == CH_ON}}; // [R13]
	assign cif.on = (r.st == CH_ON);
	assign cif.ready = (r.st == CH_LOCK) && !cif.occ && !cif.auto_rst;
	assign cif.err = (r.st == CH_ERR);
endmodule

// file: rtl/sos_sigmux.sv
`timescale 1ns/1ps
module sos_sigmux import sos_pkg::*; (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// sources and selection
	input wire logic [NSRC-1:0] i_src,
	input wire logic [NSIG*SELW-1:0] i_sel,
	// indication outputs
	output logic [NSIG-1:0] o_sig
);
	typedef struct packed {
		logic [NSIG-1:0] sig;
	} sos_mux_st_t;

	sos_mux_st_t r;
	sos_mux_st_t n;

	function automatic logic sos_pick(input logic [NSRC-1:0] src, input logic [SELW-1:0] sel);
		sos_pick = (sel == SRC_ZERO) ? 1'b0 : src[sel];
	endfunction

	always_comb begin
		n = r;
		for (int k = 0; k < NSIG; k++) begin
			n.sig[k] = sos_pick(i_src, i_sel[k*SELW +: SELW]); // [R9]
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '{sig: '0};
		end else begin
			r <= n;
		end
	end

	assign o_sig = r.sig;
endmodule

// file: rtl/sos_top.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// [R1] object in protective field switches pair off
// [R2] re-enable only when clear, auto or acknowledged
// [R3] two independent functions, each own pair
// [R4] single function: selectable delay before second pair
// [R5] six indicators, three per function
// [R6] red/green: red off, flash error, green on
// [R7] yellow: blink occupied, steady when ready
// [R8] blue lit while warning field occupied
// [R9] nine indication outputs with selectable sources
// [R10] monitor and release ten field pairs each
// [R11] optional dynamic contactor feedback monitoring
// [R12] warning fields never switch safety outputs
// [R13] pair channels equal, disagreement is error
module sos_top import sos_pkg::*; #(
	parameter int BLINK_LIM = BLINK_CYC,
	parameter int CFB_LIM = CFB_CYC
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,

	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,

	// field evaluation, index 0 is function A, 1 is function B
	input wire logic [NFN-1:0] i_prot_occ,
	input wire logic [NFN-1:0] i_warn_occ,
	input wire logic [FLDW-1:0] i_field_sel_a,
	input wire logic [FLDW-1:0] i_field_sel_b,

	// machine side
	input wire logic [NFN-1:0] i_restart_ack,
	input wire logic [NFN-1:0] i_contactor_fb,
	input wire logic [1:0] i_ssw_rb_a,
	input wire logic [1:0] i_ssw_rb_b,
	output logic [1:0] o_safety_switching_output_a,
	output logic [1:0] o_safety_switching_output_b,

	// indicators and indication outputs
	output logic [NFN-1:0] o_led_red,
	output logic [NFN-1:0] o_led_green,
	output logic [NFN-1:0] o_led_yellow,
	output logic [NFN-1:0] o_led_blue,
	output logic [NSIG-1:0] o_ind,

	// interrupt
	output logic o_irq
);
	typedef struct packed {
		// software registers
		logic [31:0] ctrl;
		logic [31:0] dly;
		logic [NSIG*SELW-1:0] sel;
		logic [NIRQ-1:0] irq_st;
		logic [NIRQ-1:0] irq_en;
		// read data, zero outside the cycle after a read
		logic [31:0] rdata;

		// flash timebase and switch-off delay
		logic [31:0] blink_cnt;
		logic blink;
		logic [31:0] dly_cnt;

		// field pair changeover
		logic [NFN-1:0][FLDW-1:0] fld_act;
		logic [NFN-1:0][FLDW-1:0] fld_prev;
		logic [NFN-1:0] fld_err;

		// last levels, for the interrupt edge detectors
		logic [NFN-1:0] on_d;
		logic [NFN-1:0] err_d;
		logic [NFN-1:0] warn_d;
		logic [NFN-1:0] ferr_d;

		// indicator drive
		logic [NFN-1:0] red;
		logic [NFN-1:0] green;
		logic [NFN-1:0] yellow;
		logic [NFN-1:0] blue;
	} sos_top_st_t;

	sos_top_st_t r;
	sos_top_st_t n;

	// channel results
	logic [NFN-1:0] on;
	logic [NFN-1:0] ready;
	logic [NFN-1:0] err;

	// effective occupancy and per-function wiring
	logic [NFN-1:0] occ_eff;
	logic [NFN-1:0][FLDW-1:0] fsel;
	logic [NFN-1:0][1:0] rb;
	logic [NSRC-1:0] src;
	logic dual;
	logic occ_b_single;

	sos_chan_if u_cif[NFN] ();

	assign dual = r.ctrl[CTL_DUAL];
	assign fsel[0] = i_field_sel_a;
	assign fsel[1] = i_field_sel_b;
	assign rb[0] = i_ssw_rb_a;
	assign rb[1] = i_ssw_rb_b;

	// single mode: second pair goes off a set time after the first
	assign occ_b_single = !on[0] && (!r.ctrl[CTL_DLY_EN] || (r.dly_cnt >= r.dly)); // [R4]
	// only the protective field reaches the channels, warnings stay out
	assign occ_eff[0] = i_prot_occ[0]; // [R12]
	assign occ_eff[1] = dual ? i_prot_occ[1] : occ_b_single; // [R3] [R4]

	generate
		for (genvar g = 0; g < NFN; g++) begin : g_fn
			assign u_cif[g].occ = occ_eff[g]; // [R1]
			assign u_cif[g].ack = i_restart_ack[g];
			// in single mode the second pair always restarts by itself
			assign u_cif[g].auto_rst = r.ctrl[CTL_AUTO + g] || (g != 0 && !dual); // [R2]
			assign u_cif[g].cfb_en = r.ctrl[CTL_CFB + g]; // [R11]
			assign u_cif[g].fb = i_contactor_fb[g];
			assign u_cif[g].rb = rb[g];
			assign u_cif[g].fault = r.fld_err[g] && (g == 0 || dual); // [R10]

			// results back from the channel
			assign on[g] = u_cif[g].on;
			assign ready[g] = u_cif[g].ready;
			assign err[g] = u_cif[g].err;

			// one state machine per protective function
			sos_chan #(
				.CFB_LIM(CFB_LIM)
			) u_chan (
				.i_clk_sys(i_clk_sys),
				.i_rst_n(i_rst_n),
				.cif(u_cif[g].chan)
			);
		end
	endgenerate

	// both channels of a pair come from one state bit
	assign o_safety_switching_output_a = u_cif[0].pair; // [R3]
	assign o_safety_switching_output_b = u_cif[1].pair; // [R3]

	always_comb begin
		src = '0;
		// pair states
		src[SRC_ON_A] = on[0];
		src[SRC_ON_B] = on[1];
		// warning fields
		src[SRC_WARN_A] = i_warn_occ[0];
		src[SRC_WARN_B] = i_warn_occ[1];
		// channel errors
		src[SRC_ERR_A] = err[0];
		src[SRC_ERR_B] = err[1];
		// waiting for a restart acknowledge
		src[SRC_READY_A] = ready[0];
		src[SRC_READY_B] = ready[1];
		// invalid field pair codes
		src[SRC_FERR_A] = r.fld_err[0];
		src[SRC_FERR_B] = r.fld_err[1];
		// protective field as the channels see it
		src[SRC_OCC_A] = occ_eff[0];
		src[SRC_OCC_B] = occ_eff[1];
	end

	sos_sigmux u_mux (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_src(src),
		.i_sel(r.sel),
		.o_sig(o_ind)
	);

	always_comb begin
		n = r;
		// register writes
		if (i_wr) begin
			unique case (i_addr)
				ADR_CTRL: n.ctrl = i_wdata;
				ADR_DLY: n.dly = i_wdata; // [R4]
				ADR_SEL0: n.sel[31:0] = i_wdata; // [R9]
				ADR_SEL1: n.sel[NSIG*SELW-1:32] = i_wdata[NSIG*SELW-33:0]; // [R9]
				ADR_IRQ_EN: n.irq_en = i_wdata[NIRQ-1:0];
				ADR_IRQ_CLR: n.irq_st = r.irq_st & ~i_wdata[NIRQ-1:0];
				// read-only and unmapped addresses ignore writes
				default: n.ctrl = r.ctrl;
			endcase
		end

		// events set after clear so a simultaneous event is kept
		for (int f = 0; f < NFN; f++) begin
			if (r.on_d[f] && !on[f]) begin
				n.irq_st[IRQ_OFF + f] = 1'b1;
			end
			if (!r.err_d[f] && err[f]) begin
				n.irq_st[IRQ_ERR + f] = 1'b1;
			end
			if (!r.warn_d[f] && i_warn_occ[f]) begin
				n.irq_st[IRQ_WARN + f] = 1'b1;
			end
			if (!r.ferr_d[f] && r.fld_err[f]) begin
				n.irq_st[IRQ_FLD + f] = 1'b1;
			end
		end

		// remember this cycle's levels for the edge detectors
		n.on_d = on;
		n.err_d = err;
		n.warn_d = i_warn_occ;
		n.ferr_d = r.fld_err;

		// read data stand only in the cycle after the strobe
		n.rdata = 32'h0000_0000;
		if (i_rd) begin
			unique case (i_addr)
				ADR_CTRL: n.rdata = r.ctrl;
				ADR_STAT: begin
					n.rdata[STB_ON +: NFN] = on;
					n.rdata[STB_READY +: NFN] = ready;
					n.rdata[STB_ERR +: NFN] = err;
					n.rdata[STB_FERR +: NFN] = r.fld_err;
					n.rdata[STB_OCC +: NFN] = occ_eff;
					n.rdata[STB_WARN +: NFN] = i_warn_occ;
				end
				ADR_FIELD: n.rdata[2*FLDW-1:0] = r.fld_act; // [R10]
				ADR_DLY: n.rdata = r.dly;
				ADR_SEL0: n.rdata = r.sel[31:0];
				ADR_SEL1: n.rdata[NSIG*SELW-33:0] = r.sel[NSIG*SELW-1:32];
				ADR_IRQ_ST: n.rdata[NIRQ-1:0] = r.irq_st;
				ADR_IRQ_EN: n.rdata[NIRQ-1:0] = r.irq_en;
				// the clear register and unmapped addresses read as zero
				default: n.rdata = 32'h0000_0000;
			endcase
		end

		// field pair changeover: a valid code held two cycles is released
		for (int f = 0; f < NFN; f++) begin
			n.fld_prev[f] = fsel[f];
			n.fld_err[f] = !sos_fld_ok(fsel[f]); // [R10]
			if (sos_fld_ok(fsel[f]) && (fsel[f] == r.fld_prev[f])) begin
				n.fld_act[f] = fsel[f]; // [R10]
			end
		end

		// switch-off delay counter for the second pair
		if (on[0]) begin
			n.dly_cnt = 32'h0000_0000;
		end else if (r.dly_cnt < r.dly) begin
			n.dly_cnt = r.dly_cnt + 32'h0000_0001; // [R4]
		end

		// flash timebase
		if (r.blink_cnt >= 32'(BLINK_LIM - 1)) begin
			n.blink_cnt = 32'h0000_0000;
			n.blink = !r.blink;
		end else begin
			n.blink_cnt = r.blink_cnt + 32'h0000_0001;
		end

		// indicators, function A first then B
		for (int f = 0; f < NFN; f++) begin
			n.red[f] = err[f] ? r.blink : !on[f]; // [R5] [R6]
			n.green[f] = on[f] && !err[f]; // [R6]
			n.yellow[f] = occ_eff[f] ? r.blink : ready[f]; // [R7]
			n.blue[f] = i_warn_occ[f]; // [R8] [R12]
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '{
				ctrl: CTRL_RST,
				dly: DLY_RST,
				sel: '0,
				irq_st: '0,
				irq_en: '0,
				rdata: 32'h0000_0000,
				blink_cnt: 32'h0000_0000,
				blink: 1'b0,
				dly_cnt: 32'h0000_0000,
				fld_act: '0,
				fld_prev: '0,
				fld_err: '0,
				on_d: '0,
				err_d: '0,
				warn_d: '0,
				ferr_d: '0,
				red: '0,
				green: '0,
				yellow: '0,
				blue: '0
			};
		end else begin
			r <= n;
		end
	end

	// read data and indicator outputs come straight from flip-flops
	assign o_rdata = r.rdata;
	assign o_led_red = r.red;
	assign o_led_green = r.green;
	assign o_led_yellow = r.yellow;
	assign o_led_blue = r.blue;
	// level interrupt, decoded from two registers
	assign o_irq = |(r.irq_st & r.irq_en);
endmodule

// file: bench/sos_machine.sv
`timescale 1ns/1ps
module sos_machine (
	// clock and pairs
	input wire logic i_clk_sys,
	input wire logic [1:0] i_pair_a,
	input wire logic [1:0] i_pair_b,
	// faults
	input wire logic i_weld_a,
	input wire logic i_rb_fault,
	// returns
	output logic [1:0] o_fb,
	output logic [1:0] o_rb_a
);
	// contactors release a cycle after their pair drops; a welded one stays in
	always_ff @(posedge i_clk_sys) begin
		o_fb <= {i_pair_b == 2'b00, i_pair_a == 2'b00 && !i_weld_a};
	end
	// a broken channel reads back inverted
	assign o_rb_a = {i_pair_a[1] ^ i_rb_fault, i_pair_a[0]};
endmodule

// file: bench/sos_top_monitor.sv
`timescale 1ns/1ps
module sos_top_monitor import sos_pkg::*; (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// watched signals
	input wire logic i_rd,
	input wire logic [NFN-1:0] i_prot_occ,
	input wire logic [NFN-1:0] i_warn_occ,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] o_safety_switching_output_a,
	input wire logic [1:0] o_safety_switching_output_b,
	input wire logic [NFN-1:0] o_led_red,
	input wire logic [NFN-1:0] o_led_green,
	input wire logic [NFN-1:0] o_led_blue
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	wire [1:0] pa = o_safety_switching_output_a;
	wire [1:0] pb = o_safety_switching_output_b;
	sequence s_rise_a;
		pa != 2'b11 ##1 pa == 2'b11;
	endsequence
	a_occ_pair_off: assert property (i_prot_occ[0] && pa == 2'b11 |=> pa == 2'b00)
		else $error("pair A stayed on");
	a_rise_when_clear: assert property (s_rise_a |-> !$past(i_prot_occ[0]))
		else $error("pair A rose while occupied");
	a_pair_equal: assert property (pa[0] == pa[1] && pb[0] == pb[1])
		else $error("pair channels differ");
	a_green_follows: assert property (o_led_green[0] == ($past(pa) == 2'b11))
		else $error("green A wrong");
	a_led_excl: assert property ((o_led_red & o_led_green) == 2'b00)
		else $error("red and green together");
	a_blue_on: assert property (i_warn_occ[0] [*4] |-> o_led_blue[0])
		else $error("blue A dark");
	a_blue_off: assert property (!i_warn_occ[0] [*4] |-> !o_led_blue[0])
		else $error("blue A lit");
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not idle");
endmodule
bind sos_top sos_top_monitor u_mon (.i_clk_sys, .i_rst_n, .i_rd, .i_prot_occ, .i_warn_occ,
	.o_rdata, .o_safety_switching_output_a, .o_safety_switching_output_b,
	.o_led_red, .o_led_green, .o_led_blue);

// file: bench/sos_top_tb.sv
`timescale 1ns/1ps
module sos_top_tb;
	import sos_pkg::*;
	logic i_clk_sys, i_rst_n = 0, i_wr = 0, i_rd = 0, weld = 0, rbf = 0;
	logic [7:0] i_addr = 8'h0;
	logic [31:0] i_wdata = 32'h0, o_rdata, rd_v;
	logic [1:0] occ = 0, warn = 0, ack = 0, seen;
	logic [1:0] fb, rb_a, pa, pb, red, green, yel, blue;
	logic [3:0] fa = 4'h0, fbs = 4'h0;
	logic [8:0] ind;
	logic irq;
	int errors = 0, tests_run = 0;
	initial begin
		i_clk_sys = 1'b0;
		forever #4 i_clk_sys = ~i_clk_sys;
	end
	sos_top #(.BLINK_LIM(4), .CFB_LIM(8)) DUT (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .i_prot_occ(occ), .i_warn_occ(warn), .i_field_sel_a(fa),
		.i_field_sel_b(fbs), .i_restart_ack(ack), .i_contactor_fb(fb), .i_ssw_rb_a(rb_a),
		.i_ssw_rb_b(pb), .o_safety_switching_output_a(pa), .o_safety_switching_output_b(pb),
		.o_led_red(red), .o_led_green(green), .o_led_yellow(yel), .o_led_blue(blue),
		.o_ind(ind), .o_irq(irq));
	sos_machine MACH (.i_clk_sys, .i_pair_a(pa), .i_pair_b(pb), .i_weld_a(weld),
		.i_rb_fault(rbf), .o_fb(fb), .o_rb_a(rb_a));
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		@(negedge i_clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		@(negedge i_clk_sys);
		d = o_rdata;
	endtask
	task automatic pulse_ack(input logic [1:0] m);
		@(posedge i_clk_sys) ack <= m;
		@(posedge i_clk_sys) ack <= 2'b00;
	endtask
	task automatic t_regs;
		chk(red, 2'b11);
		chk(yel, 2'b11);
		rd(ADR_CTRL, rd_v);
		chk(rd_v, CTRL_RST);
		rd(ADR_DLY, rd_v);
		chk(rd_v, DLY_RST);
		wr(8'h24, 32'hFFFF_FFFF);
		rd(8'h24, rd_v);
		chk(rd_v, 32'h0);
		rd(ADR_IRQ_CLR, rd_v);
		chk(rd_v, 32'h0);
	endtask
	task automatic t_restart;
		wr(ADR_IRQ_EN, 32'h3);
		@(posedge i_clk_sys) ack <= 2'b01;
		cyc(2);
		chk(pa, 2'b11);
		@(posedge i_clk_sys) ack <= 2'b00;
		cyc(1);
		chk(green, 2'b01);
		chk(yel, 2'b10);
		@(posedge i_clk_sys) occ <= 2'b01;
		cyc(2);
		chk(pa, 2'b00);
		@(posedge i_clk_sys) ack <= 2'b01;
		cyc(3);
		chk(pa, 2'b00);
		chk(irq, 1'b1);
		rd(ADR_IRQ_ST, rd_v);
		chk(rd_v[1:0], 2'b01);
		seen = 2'b00;
		repeat (12) begin
			cyc(1);
			seen[yel[0]] = 1'b1;
		end
		chk(seen, 2'b11);
		wr(ADR_IRQ_CLR, 32'h1);
		chk(irq, 1'b0);
		@(posedge i_clk_sys) ack <= 2'b00;
		@(posedge i_clk_sys) occ <= 2'b00;
		cyc(4);
		chk(pa, 2'b00);
		chk(yel, 2'b11);
		wr(ADR_CTRL, 32'h3);
		cyc(2);
		chk(pa, 2'b11);
	endtask
	task automatic t_dual;
		wr(ADR_SEL0, 32'h123);
		wr(ADR_SEL1, {28'h0, SRC_ERR_A});
		pulse_ack(2'b10);
		@(posedge i_clk_sys) warn <= 2'b01;
		cyc(5);
		chk({pa, pb}, 4'hF);
		chk(blue, 2'b01);
		chk(ind, 9'h007);
		@(posedge i_clk_sys) occ <= 2'b10;
		cyc(2);
		chk({pa, pb}, 4'hC);
		@(posedge i_clk_sys) occ <= 2'b00;
		warn <= 2'b00;
		cyc(5);
		chk(blue, 2'b00);
		chk(ind, 9'h004);
	endtask
	task automatic t_field;
		wr(ADR_IRQ_EN, 32'h40);
		@(posedge i_clk_sys) fa <= 4'hA;
		cyc(4);
		chk(pa, 2'b00);
		chk(irq, 1'b1);
		rd(ADR_STAT, rd_v);
		chk({rd_v[6], rd_v[4]}, 2'b11);
		chk(ind[8], 1'b1);
		seen = 2'b00;
		repeat (12) begin
			cyc(1);
			seen[red[0]] = 1'b1;
		end
		chk(seen, 2'b11);
		@(posedge i_clk_sys) fa <= 4'h3;
		cyc(4);
		rd(ADR_FIELD, rd_v);
		chk(rd_v[3:0], 4'h3);
		pulse_ack(2'b01);
		cyc(4);
		chk(pa, 2'b11);
		wr(ADR_IRQ_EN, 32'h0);
		chk(irq, 1'b0);
		wr(ADR_IRQ_CLR, 32'hFF);
	endtask
	task automatic t_cfb;
		wr(ADR_CTRL, 32'hB);
		@(posedge i_clk_sys) rbf <= 1'b1;
		cyc(3);
		chk(pa, 2'b00);
		@(posedge i_clk_sys) rbf <= 1'b0;
		pulse_ack(2'b01);
		cyc(4);
		chk(pa, 2'b11);
		@(posedge i_clk_sys) weld <= 1'b1;
		occ <= 2'b01;
		cyc(14);
		rd(ADR_STAT, rd_v);
		chk(rd_v[4], 1'b1);
		@(posedge i_clk_sys) weld <= 1'b0;
		occ <= 2'b00;
		pulse_ack(2'b01);
		cyc(4);
		chk(pa, 2'b11);
	endtask
	task automatic t_single;
		wr(ADR_DLY, 32'h5);
		wr(ADR_CTRL, 32'h22);
		cyc(4);
		chk(pb, 2'b11);
		@(posedge i_clk_sys) occ <= 2'b01;
		cyc(5);
		chk({pa, pb}, 4'h3);
		cyc(6);
		chk(pb, 2'b00);
		@(posedge i_clk_sys) occ <= 2'b00;
		cyc(6);
		chk({pa, pb}, 4'hF);
	endtask
	task automatic final_report;
		if (errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#20us;
		errors++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		cyc(3);
		t_regs();
		t_restart();
		t_dual();
		t_field();
		t_cfb();
		t_single();
		final_report();
	end
endmodule
